// ---- design/ppc_pkg.sv ----
package ppc_pkg;
    // PIPE power states
    localparam logic [1:0] PWR_P0  = 2'h0;
    localparam logic [1:0] PWR_P0S = 2'h1;
    localparam logic [1:0] PWR_P1  = 2'h2;
    localparam logic [1:0] PWR_P2  = 2'h3;
    // RxStatus codes
    localparam logic [2:0] RXSTAT_OK       = 3'h0;
    localparam logic [2:0] RXSTAT_DET_NONE = 3'h0;
    localparam logic [2:0] RXSTAT_DET_FND  = 3'h3;
    // Comma code group /K28.5/
    localparam logic [7:0] COMMA_BYTE = 8'hbc;
    // Lane synchronisation figures
    localparam logic [2:0] SYNC_COMMAS   = 3'h4;
    localparam logic [4:0] SYNC_ERR_LOSS = 5'h11;
    localparam logic [4:0] SYNC_GOOD_RUN = 5'h10;
    // Timing
    localparam int         CLK_PERIOD_NS  = 4;
    localparam int         EIDLE_ENTRY_NS = 8;
    localparam int         EIDLE_MIN_NS   = 20;
    localparam int         EIDLE_ENTRY_CYC = EIDLE_ENTRY_NS / CLK_PERIOD_NS;
    localparam logic [2:0] EIDLE_MIN_CYC   = 3'((EIDLE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [3:0] DET_LEAD_CYC    = 4'ha;
    // One decoded code group
    typedef struct packed {
        logic [7:0] data;
        logic       k;
        logic       err;
    } ppc_sym_t;
    // Detection state machine
    typedef enum logic [2:0] {
        DET_IDLE = 3'h1,
        DET_RUN  = 3'h2,
        DET_HOLD = 3'h4
    } ppc_det_state_t;
    // Lane synchronisation state machine
    typedef enum logic [1:0] {
        SYN_LOSS = 2'h1,
        SYN_LOCK = 2'h2
    } ppc_syn_state_t;
endpackage : ppc_pkg

// ---- design/ppc_channel.sv ----
`timescale 1ns/100ps
`default_nettype none
module ppc_channel #(
    parameter int BYTES = 1                               // 1: hard-block 8-bit mode, 2: 16-bit mode
) (
    input  wire logic                      sys_clk_i,               // Parallel clock
    input  wire logic                      arst_n_i,                // Async reset, active low
    input  wire logic [8*BYTES-1:0]        tx_data_i,               // TxData
    input  wire logic [BYTES-1:0]          tx_datak_i,              // TxDataK
    input  wire logic                      tx_detect_rx_i,          // TxDetectRx/Loopback
    input  wire logic                      tx_elec_idle_i,          // TxElecIdle
    input  wire logic                      tx_compliance_i,         // TxCompliance
    input  wire logic                      receive_polarity_invert_i, // RxPolarity
    input  wire logic [1:0]                power_down_i,            // PowerDown
    input  wire logic                      elecidle_infer_en_i,     // Inference enabled
    input  wire logic                      infer_idle_i,            // Inferred idle from inference logic
    output logic      [8*BYTES-1:0]        rx_data_o,               // RxData
    output logic      [BYTES-1:0]          rx_datak_o,              // RxDataK
    output logic                           rx_word_valid_o,         // Buffer head holds a word
    input  wire logic                      rx_ready_i,              // MAC takes the head word
    output logic                           rx_valid_o,              // RxValid
    output logic                           phy_status_o,            // PhyStatus
    output logic                           rx_elec_idle_o,          // RxElecIdle
    output logic      [2:0]                rx_status_o,             // RxStatus
    input  wire ppc_pkg::ppc_sym_t [BYTES-1:0] dec_sym_i,           // Decoded code groups
    input  wire logic                      dec_valid_i,             // Decoder word valid
    output logic                           dec_ready_o,             // Buffer can take a word
    output logic      [8*BYTES-1:0]        enc_data_o,              // To encoder
    output logic      [BYTES-1:0]          enc_datak_o,             // To encoder
    output logic                           enc_force_disp_o,        // Negative disparity force
    output logic                           tx_buf_idle_o,           // Transmit buffer idle
    output logic                           loopback_o,              // Loopback in P0
    output logic                           pma_rx_invert_o,         // Receive polarity to PMA
    output logic                           det_start_o,             // Pulse: start detect circuit
    input  wire logic                      det_done_i,              // Detect circuit done (async)
    input  wire logic                      det_found_i,             // Receiver found (async)
    input  wire logic                      sig_detect_i             // Receiver signal detect (async)
);
    // Pin synchronisers: sig_detect, det_done, det_found
    logic [2:0] pin_in, pin_s1, pin_s2;
    logic [2:0] pin_s3, pin_f, next_pin_f;
    assign pin_in = {det_found_i, det_done_i, sig_detect_i};
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_pin
            always_comb begin
                next_pin_f[gi] = (pin_s2[gi] == pin_s3[gi]) ? pin_s3[gi] : pin_f[gi];
            end
            always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
                if (!arst_n_i) begin
                    pin_s1[gi] <= 1'b0;
                    pin_s2[gi] <= 1'b0;
                    pin_s3[gi] <= 1'b0;
                    pin_f[gi]  <= 1'b0;
                end else begin
                    pin_s1[gi] <= pin_in[gi];
                    pin_s2[gi] <= pin_s1[gi];
                    pin_s3[gi] <= pin_s2[gi];
                    pin_f[gi]  <= next_pin_f[gi];
                end
            end
        end
    endgenerate

    // Transmit path; each bonded lane is its own instance, skew handled by the MAC
    logic [8*BYTES-1:0] next_enc_data;
    logic [BYTES-1:0]   next_enc_datak;
    logic               eidle_want, next_tx_buf_idle, det_busy;
    logic [2:0]         eidle_cnt, next_eidle_cnt;
    always_comb begin
        next_enc_data  = tx_data_i;
        next_enc_datak = tx_datak_i;
        // The MAC request and any state other than P0 idle the driver; detect needs it tri-stated
        eidle_want = tx_elec_idle_i || (power_down_i != ppc_pkg::PWR_P0) || det_busy;
        // Idle held at least the minimum time even if the MAC drops early
        next_tx_buf_idle = eidle_want || (tx_buf_idle_o && (eidle_cnt < ppc_pkg::EIDLE_MIN_CYC));
        next_eidle_cnt   = eidle_cnt;
        if (!next_tx_buf_idle) begin
            next_eidle_cnt = 3'h0;
        end else if (eidle_cnt < ppc_pkg::EIDLE_MIN_CYC) begin
            next_eidle_cnt = eidle_cnt + 3'h1;
        end
    end
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            enc_data_o       <= '0;
            enc_datak_o      <= '0;
            enc_force_disp_o <= 1'b0;
            tx_buf_idle_o    <= 1'b1;
            eidle_cnt        <= 3'h0;
            loopback_o       <= 1'b0;
            pma_rx_invert_o  <= 1'b0;
        end else begin
            enc_data_o       <= next_enc_data;
            enc_datak_o      <= next_enc_datak;
            enc_force_disp_o <= tx_compliance_i;
            tx_buf_idle_o    <= next_tx_buf_idle;                    // One cycle, inside 8 ns
            eidle_cnt        <= next_eidle_cnt;
            loopback_o       <= tx_detect_rx_i && (power_down_i == ppc_pkg::PWR_P0);
            pma_rx_invert_o  <= receive_polarity_invert_i;
        end
    end

    // Receiver detection
    ppc_pkg::ppc_det_state_t det_state;
    ppc_pkg::ppc_det_state_t next_det_state;
    logic [3:0] lead_cnt, next_lead_cnt;
    logic       done_d, done_rise, next_det_start, next_phy_status;
    logic [2:0] next_rx_status;
    assign det_busy  = (det_state == ppc_pkg::DET_RUN);
    assign done_rise = pin_f[1] && !done_d;
    always_comb begin
        next_det_state  = det_state;
        next_det_start  = 1'b0;
        next_phy_status = 1'b0;
        next_rx_status  = ppc_pkg::RXSTAT_OK;
        next_lead_cnt   = lead_cnt;
        if (!tx_elec_idle_i) begin
            next_lead_cnt = 4'h0;
        end else if (lead_cnt < ppc_pkg::DET_LEAD_CYC) begin
            next_lead_cnt = lead_cnt + 4'h1;
        end
        case (det_state)
            ppc_pkg::DET_IDLE: begin
                // Request without enough idle lead is ignored
                if (tx_detect_rx_i && (power_down_i == ppc_pkg::PWR_P1) &&
                    (lead_cnt >= ppc_pkg::DET_LEAD_CYC)) begin
                    next_det_state = ppc_pkg::DET_RUN;
                    next_det_start = 1'b1;
                end
            end
            ppc_pkg::DET_RUN: begin
                if (done_rise) begin
                    next_det_state  = ppc_pkg::DET_HOLD;
                    next_phy_status = 1'b1;
                    next_rx_status  = pin_f[2] ? ppc_pkg::RXSTAT_DET_FND : ppc_pkg::RXSTAT_DET_NONE;
                end
            end
            ppc_pkg::DET_HOLD: begin
                if (!tx_detect_rx_i) begin
                    next_det_state = ppc_pkg::DET_IDLE;
                end
            end
            default: begin
                next_det_state = ppc_pkg::DET_IDLE;
            end
        endcase
    end
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            det_state    <= ppc_pkg::DET_IDLE;
            lead_cnt     <= 4'h0;
            done_d       <= 1'b0;
            det_start_o  <= 1'b0;
            phy_status_o <= 1'b0;
            rx_status_o  <= ppc_pkg::RXSTAT_OK;
        end else begin
            det_state    <= next_det_state;
            lead_cnt     <= next_lead_cnt;
            done_d       <= pin_f[1];
            det_start_o  <= next_det_start;
            phy_status_o <= next_phy_status;
            rx_status_o  <= next_rx_status;
        end
    end

    // Receive electrical idle; flopped from the filtered detect, or from the inferred idle when inference is enabled
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rx_elec_idle_o <= 1'b1;
        end else begin
            rx_elec_idle_o <= elecidle_infer_en_i ? infer_idle_i : !pin_f[0];
        end
    end

    // Two-entry receive buffer, head always in slot 0 so outputs stay registered
    ppc_pkg::ppc_sym_t [BYTES-1:0] buf_q [2];
    ppc_pkg::ppc_sym_t [BYTES-1:0] next_buf [2];
    logic [1:0] buf_cnt;
    logic [1:0] next_buf_cnt;
    logic       push;
    logic       pop;
    assign dec_ready_o     = (buf_cnt != 2'h2);
    assign rx_word_valid_o = (buf_cnt != 2'h0);
    assign push            = dec_valid_i && dec_ready_o;
    assign pop             = rx_word_valid_o && rx_ready_i;
    always_comb begin
        next_buf[0]  = buf_q[0];
        next_buf[1]  = buf_q[1];
        next_buf_cnt = buf_cnt;
        if (pop) begin
            next_buf[0] = buf_q[1];
        end
        if (push) begin
            next_buf[(pop ? buf_cnt - 2'h1 : buf_cnt) == 2'h0 ? 0 : 1] = dec_sym_i;
        end
        next_buf_cnt = 2'(buf_cnt + {1'b0, push} - {1'b0, pop});
    end
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            buf_q[0] <= '0;
            buf_q[1] <= '0;
            buf_cnt  <= 2'h0;
        end else begin
            buf_q[0] <= next_buf[0];
            buf_q[1] <= next_buf[1];
            buf_cnt  <= next_buf_cnt;
        end
    end
    generate
        for (gi = 0; gi < BYTES; gi++) begin : g_out
            assign rx_data_o[8*gi +: 8] = buf_q[0][gi].data;
            assign rx_datak_o[gi]       = buf_q[0][gi].k;
        end
    endgenerate

    // Lane synchronisation on accepted code groups, alignment pattern is the decoded /K28.5/ comma byte with K set
    ppc_pkg::ppc_syn_state_t syn_state;
    ppc_pkg::ppc_syn_state_t next_syn_state;
    logic [2:0] comma_cnt, next_comma_cnt;
    logic [4:0] err_cnt, next_err_cnt;
    logic [4:0] good_cnt, next_good_cnt;
    always_comb begin
        next_syn_state = syn_state;
        next_comma_cnt = comma_cnt;
        next_err_cnt   = err_cnt;
        next_good_cnt  = good_cnt;
        for (int b = 0; b < BYTES; b++) begin
            if (push) begin
                case (next_syn_state)
                    ppc_pkg::SYN_LOSS: begin
                        if (dec_sym_i[b].err) begin
                            next_comma_cnt = 3'h0;
                        end else if (dec_sym_i[b].k && (dec_sym_i[b].data == ppc_pkg::COMMA_BYTE)) begin
                            next_comma_cnt = next_comma_cnt + 3'h1;
                            if (next_comma_cnt >= ppc_pkg::SYNC_COMMAS) begin
                                next_syn_state = ppc_pkg::SYN_LOCK;
                                next_comma_cnt = 3'h0;
                                next_err_cnt   = 5'h0;
                                next_good_cnt  = 5'h0;
                            end
                        end
                    end
                    ppc_pkg::SYN_LOCK: begin
                        if (dec_sym_i[b].err) begin
                            next_good_cnt = 5'h0;
                            next_err_cnt  = next_err_cnt + 5'h1;
                            if (next_err_cnt >= ppc_pkg::SYNC_ERR_LOSS) begin
                                next_syn_state = ppc_pkg::SYN_LOSS;
                                next_err_cnt   = 5'h0;
                            end
                        end else begin
                            next_good_cnt = next_good_cnt + 5'h1;
                            if (next_good_cnt >= ppc_pkg::SYNC_GOOD_RUN) begin
                                next_good_cnt = 5'h0;
                                if (next_err_cnt != 5'h0) begin
                                    next_err_cnt = next_err_cnt - 5'h1;
                                end
                            end
                        end
                    end
                    default: begin
                        next_syn_state = ppc_pkg::SYN_LOSS;
                    end
                endcase
            end
        end
    end
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            syn_state <= ppc_pkg::SYN_LOSS;
            comma_cnt <= 3'h0;
            err_cnt   <= 5'h0;
            good_cnt  <= 5'h0;
        end else begin
            syn_state <= next_syn_state;
            comma_cnt <= next_comma_cnt;
            err_cnt   <= next_err_cnt;
            good_cnt  <= next_good_cnt;
        end
    end
    assign rx_valid_o = (syn_state == ppc_pkg::SYN_LOCK);

    // Checks
    AST_PHYSTAT_PULSE: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        phy_status_o |=> !phy_status_o) else $error("PhyStatus longer than one cycle");
    AST_DET_RESULT: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        (det_busy && done_rise) |=> phy_status_o &&
        (rx_status_o == ($past(pin_f[2]) ? 3'h3 : 3'h0))) else $error("Wrong detect result");
    AST_STATUS_QUIET: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        !phy_status_o |-> (rx_status_o == 3'h0)) else $error("RxStatus set outside PhyStatus");
    AST_DET_LEAD: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        det_start_o |-> $past(tx_elec_idle_i, 10)) else $error("Detect started without idle lead");
    AST_EIDLE_ENTRY: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        tx_elec_idle_i |-> ##[1:2] tx_buf_idle_o) else $error("Transmitter not idle in time");
    AST_LOWPWR_IDLE: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        (power_down_i != 2'h0) |=> tx_buf_idle_o) else $error("Low power without idle");
    AST_EIDLE_MIN: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        $rose(tx_buf_idle_o) |-> tx_buf_idle_o [*5]) else $error("Idle shorter than 20 ns");
    AST_RXIDLE_INV: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        !elecidle_infer_en_i |=> (rx_elec_idle_o == !$past(pin_f[0]))) else $error("RxElecIdle not inverse");
    AST_SYNC_ACQ: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        $rose(rx_valid_o) |-> ($past(comma_cnt) + 3'(BYTES) >= 3'h4)) else $error("Sync too early");
    AST_SYNC_LOSS: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        $fell(rx_valid_o) |-> ($past(err_cnt) + 5'(BYTES) >= 5'h11)) else $error("Sync lost too early");
    AST_ERR_DEC: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        (rx_valid_o && $past(rx_valid_o) && (err_cnt < $past(err_cnt))) |->
        (err_cnt == $past(err_cnt) - 5'h1)) else $error("Error count fell by more than one");
    AST_BUF_HOLD: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        (rx_word_valid_o && !rx_ready_i) |=> (rx_word_valid_o && $stable(rx_data_o) && $stable(rx_datak_o)))
        else $error("Head word lost during stall");
    COV_DET_FOUND: cover property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        phy_status_o && (rx_status_o == 3'h3));
    COV_DET_NONE: cover property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        phy_status_o && (rx_status_o == 3'h0));
    COV_SYNC_UP: cover property (@(posedge sys_clk_i) disable iff (!arst_n_i) $rose(rx_valid_o));
    COV_SYNC_DOWN: cover property (@(posedge sys_clk_i) disable iff (!arst_n_i) $fell(rx_valid_o));
    COV_BUF_STALL: cover property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        (buf_cnt == 2'h2) && dec_valid_i);
endmodule : ppc_channel
`default_nettype wire

// ---- dv/ppc_det_model.sv ----
`timescale 1ns/100ps
`default_nettype none
// Behavioural receiver-detect circuit: answers each start after a chosen delay
module ppc_det_model (
    input  wire logic       clk_i,       // Parallel clock
    input  wire logic       start_i,     // Start pulse from channel
    input  wire logic       found_cfg_i, // Result to report
    input  wire logic [3:0] delay_i,     // Answer delay in cycles
    output logic            done_o,      // Detection done level
    output logic            found_o      // Receiver found
);
    int cnt;
    int hold;
    initial begin
        done_o = 1'b0;
        found_o = 1'b0;
        cnt = 0;
        hold = 0;
    end
    always @(posedge clk_i) begin
        if (start_i) cnt <= int'(delay_i) + 3;
        else if (cnt > 1) cnt <= cnt - 1;
        // Result settles a cycle before done so the synchroniser never sees it move while done is high
        if (cnt == 3) found_o <= found_cfg_i;
        if (cnt == 2) begin
            done_o <= 1'b1;
            hold <= 8;
            cnt <= 0;
        end else if (hold > 1) hold <= hold - 1;
        else if (hold == 1) begin
            done_o <= 1'b0;
            found_o <= ~found_o;
            hold <= 0;
        end
    end
endmodule : ppc_det_model
`default_nettype wire

// ---- dv/ppc_channel_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module ppc_channel_tb;
    logic                      sys_clk_i, arst_n_i, det_req, eidle, comp, pol, ien, iidle, rdy, dvalid, sigdet, fcfg, txk;
    logic [7:0]                txd;
    logic [1:0]                pd;
    logic [3:0]                dly;
    ppc_pkg::ppc_sym_t [0:0]   sym;
    wire logic [7:0]           rxd, encd;
    wire logic [2:0]           rxs;
    wire logic                 rxk, wv, rxv, phy, rxei, dready, enck, fdisp, bidle, lpbk, inv, dstart, ddone, dfound;
    int                        n_errors, checked;

    ppc_channel #(.BYTES(1)) DUT (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .tx_data_i(txd), .tx_datak_i(txk),
        .tx_detect_rx_i(det_req), .tx_elec_idle_i(eidle), .tx_compliance_i(comp), .receive_polarity_invert_i(pol),
        .power_down_i(pd), .elecidle_infer_en_i(ien), .infer_idle_i(iidle), .rx_data_o(rxd), .rx_datak_o(rxk),
        .rx_word_valid_o(wv), .rx_ready_i(rdy), .rx_valid_o(rxv), .phy_status_o(phy), .rx_elec_idle_o(rxei),
        .rx_status_o(rxs), .dec_sym_i(sym), .dec_valid_i(dvalid), .dec_ready_o(dready), .enc_data_o(encd),
        .enc_datak_o(enck), .enc_force_disp_o(fdisp), .tx_buf_idle_o(bidle), .loopback_o(lpbk),
        .pma_rx_invert_o(inv), .det_start_o(dstart), .det_done_i(ddone), .det_found_i(dfound), .sig_detect_i(sigdet));
    ppc_det_model PEER (.clk_i(sys_clk_i), .start_i(dstart), .found_cfg_i(fcfg), .delay_i(dly),
        .done_o(ddone), .found_o(dfound));

    initial begin
        sys_clk_i = 1'b0;
        forever #2 sys_clk_i = ~sys_clk_i;
    end

    task cyc(input int n);
        repeat (n) @(posedge sys_clk_i);
    endtask : cyc
    task wrap_up;
        $display("checks %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : wrap_up
    task chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
            n_errors++;
        end
    endtask : chk
    // The bench is the MAC: holds the request until the status pulse
    task detect(input logic f, input logic [3:0] d, input logic [2:0] exp);
        int i;
        fcfg <= f;
        dly <= d;
        det_req <= 1'b1;
        for (i = 0; i < 100 && phy !== 1'b1; i++) begin
            @(posedge sys_clk_i);
            #1;
        end
        if (i == 100) begin
            n_errors++;
            wrap_up;
        end
        chk("rx_status", 8'(exp), 8'(rxs));
        cyc(1);
        det_req <= 1'b0;
        #1;
        chk("phy_status_end", 8'h0, 8'(phy));
        cyc(24);
    endtask : detect
    task push(input logic [7:0] d, input logic k, input logic e);
        int i;
        cyc(1);
        sym[0] <= '{data: d, k: k, err: e};
        dvalid <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge sys_clk_i);
            if (dready === 1'b1) break;
        end
        if (i == 20) begin
            n_errors++;
            wrap_up;
        end
        dvalid <= 1'b0;
    endtask : push

    initial begin
        int i;
        {arst_n_i, det_req, comp, pol, ien, iidle, rdy, dvalid, sigdet, fcfg, txk} = '0;
        eidle = 1'b1;
        txd = 8'h00;
        pd = ppc_pkg::PWR_P1;
        dly = 4'h0;
        sym = '0;
        n_errors = 0;
        checked = 0;
        cyc(12);
        chk("tx_buf_idle_rst", 8'h1, 8'(bidle));
        chk("rx_elec_idle_rst", 8'h1, 8'(rxei));
        arst_n_i <= 1'b1;
        cyc(12);
        $display("test reset done");
        detect(1'b1, 4'h0, ppc_pkg::RXSTAT_DET_FND);
        detect(1'b0, 4'hc, ppc_pkg::RXSTAT_DET_NONE);
        // A short idle lead must be ignored
        eidle <= 1'b0;
        cyc(2);
        eidle <= 1'b1;
        cyc(3);
        // Request dropped before the lead is complete, so nothing may start
        det_req <= 1'b1;
        for (i = 0; i < 40; i++) begin
            cyc(1);
            if (i == 4) det_req <= 1'b0;
            #1;
            if (phy === 1'b1 || dstart === 1'b1) chk("early_detect", 8'h0, 8'h1);
        end
        checked++;
        cyc(1);
        $display("test detect done");
        pd <= ppc_pkg::PWR_P0;
        eidle <= 1'b0;
        txd <= 8'h5a;
        txk <= 1'b1;
        comp <= 1'b1;
        pol <= 1'b1;
        det_req <= 1'b1;
        sigdet <= 1'b1;
        cyc(8);
        #1;
        chk("tx_buf_idle_p0", 8'h0, 8'(bidle));
        chk("enc_data", 8'h5a, encd);
        chk("enc_datak", 8'h1, 8'(enck));
        chk("force_disp", 8'h1, 8'(fdisp));
        chk("rx_invert", 8'h1, 8'(inv));
        chk("loopback", 8'h1, 8'(lpbk));
        chk("rx_elec_idle_sig", 8'h0, 8'(rxei));
        cyc(1);
        det_req <= 1'b0;
        pd <= ppc_pkg::PWR_P2;
        ien <= 1'b1;
        iidle <= 1'b1;
        cyc(3);
        #1;
        chk("tx_buf_idle_p2", 8'h1, 8'(bidle));
        chk("rx_elec_idle_inf", 8'h1, 8'(rxei));
        cyc(6);
        pd <= ppc_pkg::PWR_P0;
        eidle <= 1'b1;
        cyc(3);
        #1;
        chk("tx_buf_idle_eidle", 8'h1, 8'(bidle));
        cyc(1);
        eidle <= 1'b0;
        cyc(2);
        #1;
        chk("tx_buf_idle_exit", 8'h0, 8'(bidle));
        // A one-cycle idle request is stretched to the minimum idle time
        cyc(1);
        eidle <= 1'b1;
        cyc(1);
        eidle <= 1'b0;
        cyc(4);
        #1;
        chk("tx_idle_stretch", 8'h1, 8'(bidle));
        cyc(2);
        #1;
        chk("tx_idle_release", 8'h0, 8'(bidle));
        $display("test transmit done");
        push(8'h11, 1'b0, 1'b0);
        push(8'h22, 1'b1, 1'b0);
        #1;
        chk("dec_ready_full", 8'h0, 8'(dready));
        chk("head_word", 8'h11, rxd);
        chk("head_k", 8'h0, 8'(rxk));
        cyc(1);
        rdy <= 1'b1;
        cyc(1);
        rdy <= 1'b0;
        #1;
        chk("second_word", 8'h22, rxd);
        chk("second_k", 8'h1, 8'(rxk));
        cyc(1);
        rdy <= 1'b1;
        cyc(2);
        #1;
        chk("buffer_empty", 8'h0, 8'(wv));
        $display("test buffer done");
        repeat (3) push(ppc_pkg::COMMA_BYTE, 1'b1, 1'b0);
        cyc(2);
        #1;
        chk("sync_three", 8'h0, 8'(rxv));
        push(ppc_pkg::COMMA_BYTE, 1'b1, 1'b0);
        cyc(2);
        #1;
        chk("sync_four", 8'h1, 8'(rxv));
        repeat (16) push(8'h4a, 1'b0, 1'b1);
        repeat (16) push(8'h4a, 1'b0, 1'b0);
        push(8'h4a, 1'b0, 1'b1);
        cyc(2);
        #1;
        chk("sync_after_decr", 8'h1, 8'(rxv));
        push(8'h4a, 1'b0, 1'b1);
        cyc(2);
        #1;
        chk("sync_lost", 8'h0, 8'(rxv));
        $display("test sync done");
        wrap_up;
    end
endmodule : ppc_channel_tb
`default_nettype wire
